// file: include/fan_pkg.sv
package fan_pkg;
  // register addresses
  localparam logic [7:0] ADDR_DRIVE_CFG   = 8'h4A;
  localparam logic [7:0] ADDR_STARTUP_CFG = 8'h4B;
  localparam logic [7:0] ADDR_DUTY        = 8'h4C;
  localparam logic [7:0] ADDR_FREQ        = 8'h4D;
  localparam logic [7:0] ADDR_LUT_BASE    = 8'h50;
  localparam logic [7:0] ADDR_LUT_LAST    = 8'h5F;
  // reset values
  localparam logic [7:0] RST_DRIVE_CFG    = 8'h20;
  localparam logic [7:0] RST_STARTUP_CFG  = 8'h3F;
  localparam logic [7:0] RST_FREQ         = 8'h17;
  localparam logic [7:0] RST_DUTY         = 8'h00;
  localparam logic [7:0] RST_LUT_TEMP     = 8'h7F;
  localparam logic [7:0] RST_LUT_DUTY     = 8'h3F;
  // drive config fields
  localparam int TACH_LSB = 0;
  localparam int RSVD_BIT = 2;
  localparam int CLKSEL_BIT = 3;
  localparam int POL_BIT = 4;
  localparam int MANUAL_BIT = 5;
  // startup config fields
  localparam int SUTIME_LSB = 0;
  localparam int SUDUTY_LSB = 3;
  localparam int FAST_BIT = 5;
  // masks for writable bits; top two bits read zero, except bit 6 of the temperature entries
  localparam logic [7:0] DRIVE_CFG_MASK   = 8'h3B;
  localparam logic [7:0] STARTUP_CFG_MASK = 8'h3F;
  localparam logic [7:0] FREQ_MASK        = 8'h1F;
  localparam logic [7:0] DUTY_MASK        = 8'h3F;
  localparam logic [7:0] TEMP_MASK        = 8'h7F;
  // timing
  localparam int MCLK_HZ = 20000000;
  localparam int PCLK_FAST_HZ = 360000;
  localparam int PCLK_SLOW_HZ = 1400;
  localparam int PCLK_FAST_DIV = MCLK_HZ / PCLK_FAST_HZ;
  localparam int PCLK_SLOW_DIV = MCLK_HZ / PCLK_SLOW_HZ;
  localparam int SPINUP_BASE_MS = 50;
  localparam int SPINUP_BASE_CYC = MCLK_HZ / 1000 * SPINUP_BASE_MS;
  localparam logic [5:0] DUTY_FULL = 6'h3F;
  localparam logic [5:0] DUTY_HALF = 6'h20;
  localparam logic [5:0] DUTY_3Q   = 6'h30;
  localparam logic [15:0] TACH_ALL_ONES = 16'hFFFF;
  typedef enum logic [1:0] {TACH_PLAIN, TACH_PLAIN_FFFF, TACH_SYNC_ACC, TACH_SYNC_LIGHT} tach_mode_e;
endpackage : fan_pkg

// file: verilog/fan_pwm_core.sv
`timescale 1ns/10ps
module fan_pwm_core (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       slow_clk,
  input  wire logic [4:0] freq_n,
  input  wire logic [5:0] duty,
  output logic            fan_on
);
  logic [15:0] pre_q;
  logic        ptick;
  logic [5:0]  step_q;
  logic [19:0] pos_q;
  logic        wrap;
  logic [5:0]  n_eff;
  logic [6:0]  n_twice;
  logic [15:0] pdiv;
  logic [19:0] span;
  logic [25:0] on_lim;

  assign n_eff   = (freq_n == 5'h00) ? 6'h01 : {1'b0, freq_n};
  assign n_twice = {n_eff, 1'b0};
  assign pdiv    = slow_clk ? 16'(fan_pkg::PCLK_SLOW_DIV) : 16'(fan_pkg::PCLK_FAST_DIV);
  assign ptick   = (pre_q >= pdiv - 16'h0001);
  assign wrap    = ptick && ({1'b0, step_q} + 7'h01 >= n_twice); // [R21]
  // 62 ticks of the slow divider stay below 2^20 cycles, so span never overflows
  assign span    = {13'h0000, n_twice} * {4'h0, pdiv};
  assign on_lim  = {20'h00000, duty} * {6'h00, span};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 16'h0000;
    end else if (clk_en) begin
      pre_q <= ptick ? 16'h0000 : pre_q + 16'h0001; // [R05]
    end
  end

  // period of 2n prescaler ticks, duty resolved to 1/64 of it in mclk cycles
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      step_q <= 6'h00;
      pos_q  <= 20'h00000;
    end else if (clk_en) begin
      if (wrap) begin
        step_q <= 6'h00;
        pos_q  <= 20'h00000;
      end else begin
        pos_q <= pos_q + 20'h00001;
        if (ptick) step_q <= step_q + 6'h01; // [R21]
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fan_on <= 1'b0;
    end else if (clk_en) begin
      fan_on <= (duty == fan_pkg::DUTY_FULL) || ({pos_q, 6'h00} < on_lim);
    end
  end
endmodule : fan_pwm_core

// file: verilog/fan_spinup.sv
`timescale 1ns/10ps
module fan_spinup (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic [5:0] cmd_duty,
  input  wire logic [7:0] cfg,
  input  wire logic       tach_ok,
  output logic            active,
  output logic [5:0]      spin_duty
);
  typedef enum logic [0:0] {IDLE, SPIN} spin_state_e;
  spin_state_e state_q;
  logic [31:0] cnt_q;
  logic [31:0] limit;
  logic [2:0]  t;
  logic [1:0]  d;
  logic        fast;
  logic        was_zero_q;
  logic        bypass;

  assign t    = cfg[fan_pkg::SUTIME_LSB +: 3];
  assign d    = cfg[fan_pkg::SUDUTY_LSB +: 2];
  assign fast = cfg[fan_pkg::FAST_BIT];
  assign limit = 32'(fan_pkg::SPINUP_BASE_CYC) << (t - 3'h1); // [R20] [R24]
  assign bypass = (t == 3'h0) || (d == 2'h0 && !fast); // [R17] [R18]

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      spin_duty <= fan_pkg::DUTY_FULL;
    end else if (clk_en) begin
      if (fast) spin_duty <= fan_pkg::DUTY_FULL; // [R14] [R15]
      else begin
        case (d) // [R13] [R19]
          2'h1:    spin_duty <= fan_pkg::DUTY_HALF;
          2'h2:    spin_duty <= fan_pkg::DUTY_3Q;
          default: spin_duty <= fan_pkg::DUTY_FULL;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= IDLE;
      cnt_q      <= 32'h0;
      was_zero_q <= 1'b1;
      active     <= 1'b0;
    end else if (clk_en) begin
      was_zero_q <= (cmd_duty == 6'h00);
      case (state_q)
        IDLE: begin
          cnt_q <= 32'h0;
          if (was_zero_q && cmd_duty != 6'h00 && !bypass) begin // [R23]
            state_q <= SPIN;
            active  <= 1'b1;
          end
        end
        SPIN: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q + 32'h1 >= limit || (fast && tach_ok) || cmd_duty == 6'h00) begin // [R14]
            state_q <= IDLE;
            active  <= 1'b0;
          end
        end
        default: begin
          state_q <= IDLE;
          active  <= 1'b0;
        end
      endcase
    end
  end
endmodule : fan_spinup

// file: verilog/fan_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// [R01] auto mode: duty from lookup table, read-only
// [R02] manual mode: duty and table writable
// [R03] polarity 0: pin low when fan off
// [R04] polarity 1: pin low when fan on
// [R05] clock select: 360 kHz or 1.4 kHz
// [R06] software writes zero to reserved bit 2
// [R07] tach mode 00: conventional monitoring
// [R08] tach mode 01: all ones below minimum
// [R09] tach mode 10: synced, accurate, all ones
// [R10] tach mode 11: synced, least intrusive
// [R11] fast clock forces tach mode 00
// [R12] top two config bits read zero
// [R13] normal spin-up uses duty and time fields
// [R14] fast spin-up: full until time or speed
// [R15] fast spin-up ignores duty field
// [R16] software sets tach pin as input
// [R17] time code 000 skips spin-up
// [R18] duty code 00 skips unless fast
// [R19] duty codes: 50, ~75, 100 percent
// [R20] time codes double from 50 ms
// [R21] output frequency is clock over 2n
// [R22] duty reads zero during spin-up
// [R23] spin-up starts on zero to nonzero duty
// [R24] spin-up timed from device clock
module fan_ctrl (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [6:0] remote_temp,
  input  wire logic       tach_below_min,
  input  wire logic       tach_speed_ok,
  output logic      [1:0] tach_mode_eff,
  output logic            tach_force_ones,
  output logic            pwm_in,
  output logic            pwm_out,
  output logic            pwm_oe
);
  logic [7:0] drive_cfg_q;
  logic [7:0] startup_cfg_q;
  logic [7:0] freq_q;
  logic [5:0] man_duty_q;
  logic [7:0] lut_q [0:15];
  logic [5:0] auto_duty;
  logic [5:0] cmd_duty;
  logic [5:0] run_duty;
  logic [5:0] spin_duty;
  logic       spin_active;
  logic       fan_on;
  logic       manual;
  logic       below_s1_q;
  logic       below_s2_q;
  logic       ok_s1_q;
  logic       ok_s2_q;
  logic       pin_s1_q;

  function automatic logic [7:0] wmask(input logic [7:0] addr);
    if (addr[0]) wmask = fan_pkg::DUTY_MASK;
    else         wmask = fan_pkg::TEMP_MASK;
  endfunction : wmask

  function automatic logic in_lut(input logic [7:0] addr);
    in_lut = (addr[7:4] == fan_pkg::ADDR_LUT_BASE[7:4]);
  endfunction : in_lut

  assign manual = drive_cfg_q[fan_pkg::MANUAL_BIT];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      below_s1_q <= 1'b0;
      below_s2_q <= 1'b0;
      ok_s1_q    <= 1'b0;
      ok_s2_q    <= 1'b0;
    end else if (clk_en) begin
      below_s1_q <= tach_below_min;
      below_s2_q <= below_s1_q;
      ok_s1_q    <= tach_speed_ok;
      ok_s2_q    <= ok_s1_q;
    end
  end

  // reserved bit 2 is not stored, so a stray 1 has no effect
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      drive_cfg_q   <= fan_pkg::RST_DRIVE_CFG;
      startup_cfg_q <= fan_pkg::RST_STARTUP_CFG;
      freq_q        <= fan_pkg::RST_FREQ;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        fan_pkg::ADDR_DRIVE_CFG:   drive_cfg_q <= reg_wdata & fan_pkg::DRIVE_CFG_MASK; // [R12] [R06]
        fan_pkg::ADDR_STARTUP_CFG: startup_cfg_q <= reg_wdata & fan_pkg::STARTUP_CFG_MASK; // [R12]
        fan_pkg::ADDR_FREQ:        freq_q <= reg_wdata & fan_pkg::FREQ_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      man_duty_q <= fan_pkg::RST_DUTY[5:0];
    end else if (clk_en && reg_wr && manual && reg_addr == fan_pkg::ADDR_DUTY) begin
      man_duty_q <= reg_wdata[5:0]; // [R02]
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) begin
        lut_q[i] <= i[0] ? fan_pkg::RST_LUT_DUTY : fan_pkg::RST_LUT_TEMP;
      end
    end else if (clk_en && reg_wr && manual && in_lut(reg_addr)) begin
      lut_q[reg_addr[3:0]] <= reg_wdata & wmask(reg_addr); // [R02] [R01]
    end
  end

  // highest-index pair whose threshold the temperature exceeds wins
  always_comb begin
    auto_duty = 6'h00;
    for (int p = 0; p < 8; p++) begin
      if (remote_temp > lut_q[2 * p][6:0]) begin
        auto_duty = lut_q[2 * p + 1][5:0]; // [R01]
      end
    end
  end

  assign cmd_duty = manual ? man_duty_q : auto_duty; // [R01] [R02]
  assign run_duty = spin_active ? spin_duty : cmd_duty;

  fan_spinup u_spinup (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .cmd_duty  (cmd_duty),
    .cfg       (startup_cfg_q),
    .tach_ok   (ok_s2_q),
    .active    (spin_active),
    .spin_duty (spin_duty)
  );

  fan_pwm_core u_core (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .slow_clk (drive_cfg_q[fan_pkg::CLKSEL_BIT]),
    .freq_n   (freq_q[4:0]),
    .duty     (run_duty),
    .fan_on   (fan_on)
  );

  // open drain: only ever drives low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= 1'b0;
      pwm_oe   <= 1'b1;
      pwm_out  <= 1'b0;
      pwm_in   <= 1'b0;
    end else if (clk_en) begin
      pwm_out <= 1'b0;
      if (drive_cfg_q[fan_pkg::POL_BIT]) pwm_oe <= fan_on; // [R04]
      else                               pwm_oe <= !fan_on; // [R03]
      pin_s1_q <= fan_on;
      pwm_in   <= pin_s1_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tach_mode_eff   <= 2'h0;
      tach_force_ones <= 1'b0;
    end else if (clk_en) begin
      if (!drive_cfg_q[fan_pkg::CLKSEL_BIT]) begin
        tach_mode_eff   <= 2'h0; // [R11]
        tach_force_ones <= 1'b0; // [R07]
      end else begin
        tach_mode_eff   <= drive_cfg_q[fan_pkg::TACH_LSB +: 2]; // [R09] [R10]
        tach_force_ones <= below_s2_q && (drive_cfg_q[fan_pkg::TACH_LSB +: 2] != 2'h0); // [R08]
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        fan_pkg::ADDR_DRIVE_CFG:   reg_rdata <= drive_cfg_q; // [R12]
        fan_pkg::ADDR_STARTUP_CFG: reg_rdata <= startup_cfg_q;
        fan_pkg::ADDR_FREQ:        reg_rdata <= freq_q;
        fan_pkg::ADDR_DUTY:        reg_rdata <= spin_active ? 8'h00 : {2'b00, cmd_duty}; // [R22]
        default: begin
          if (in_lut(reg_addr))                             reg_rdata <= lut_q[reg_addr[3:0]];
          else                                              reg_rdata <= 8'h00;
        end
      endcase
    end
  end
endmodule : fan_ctrl

// file: sim/fan_ctrl_properties.sv
`timescale 1ns/10ps
module fan_ctrl_properties (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       clk_en,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       tach_below_min,
  input wire logic [1:0] tach_mode_eff,
  input wire logic       tach_force_ones,
  input wire logic       pwm_in,
  input wire logic       pwm_out,
  input wire logic       pwm_oe
);
  logic [7:0] drv_q, duty_q;
  logic [3:0] calm_q, hist_q;
  logic       low_q, rd_go, wr_go, steady;
  assign rd_go = reg_rd && clk_en;
  assign wr_go = reg_wr && clk_en;
  assign steady = (hist_q == {4{pwm_in}});
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      drv_q <= 8'h20;
      duty_q <= 8'h00;
    end else if (wr_go && reg_addr == 8'h4A) begin
      drv_q <= reg_wdata & 8'h3B;
    end else if (wr_go && reg_addr == 8'h4C && drv_q[5]) begin
      duty_q <= reg_wdata & 8'h3F;
    end
  end
  // settle time since the last write or tach change; the tach inputs pass a 2-stage sync
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      calm_q <= 4'h0;
      low_q <= 1'b0;
      hist_q <= 4'h0;
    end else begin
      low_q <= tach_below_min;
      hist_q <= {hist_q[2:0], pwm_in};
      calm_q <= (wr_go || low_q != tach_below_min) ? 4'h0 : calm_q + {3'h0, calm_q != 4'hF};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  pin_low_a: assert property (pwm_out == 1'b0)
    else $error("drive pin driven high");
  cfg_top_zero_a: assert property (rd_go && reg_addr[7:1] == 7'h25 |=> reg_rdata[7:6] == 2'h0)
    else $error("config top bits not zero");
  drive_rb_a: assert property (rd_go && reg_addr == 8'h4A |=> reg_rdata == $past(drv_q))
    else $error("drive config readback wrong");
  duty_rb_a: assert property (rd_go && reg_addr == 8'h4C && drv_q[5] |=>
    reg_rdata == $past(duty_q) || reg_rdata == 8'h00) else $error("manual duty readback wrong");
  tach_mode_a: assert property (calm_q > 4'h3 |->
    tach_mode_eff == (drv_q[3] ? drv_q[1:0] : 2'h0)) else $error("effective tach mode wrong");
  fast_plain_a: assert property (calm_q > 4'h5 && !drv_q[3] |-> !tach_force_ones)
    else $error("all-ones forced on fast clock");
  force_ones_a: assert property (calm_q > 4'h5 |->
    tach_force_ones == (tach_mode_eff != 2'h0 && tach_below_min)) else $error("all-ones flag wrong");
  // pwm_oe and pwm_in have different pipeline depths, so compare mid-way in a steady run
  oe_pol_a: assert property (calm_q > 4'h7 && steady |->
    $past(pwm_oe, 2) == (drv_q[4] ~^ pwm_in)) else $error("drive pin polarity wrong");
  cover property (tach_force_ones);
  cover property (rd_go && reg_addr == 8'h4C ##1 reg_rdata == 8'h00);
  cover property ($fell(pwm_oe));
endmodule : fan_ctrl_properties
bind fan_ctrl fan_ctrl_properties fan_ctrl_properties_i (.mclk(mclk), .reset_n(reset_n),
  .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .tach_below_min(tach_below_min), .tach_mode_eff(tach_mode_eff),
  .tach_force_ones(tach_force_ones), .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe));

// file: sim/fan_model.sv
`timescale 1ns/10ps
module fan_model #(
  parameter int OK_LVL = 200
) (
  input  wire logic mclk,
  input  wire logic pin,
  input  wire logic pol,
  output logic      below_min,
  output logic      speed_ok
);
  logic [8:0] spd_q = 9'h000;
  // rotor gains speed while powered and coasts down otherwise
  always_ff @(posedge mclk) begin
    if ((pin ^ pol) && spd_q != 9'h1FF) spd_q <= spd_q + 9'h001;
    else if (!(pin ^ pol) && spd_q != 9'h000) spd_q <= spd_q - 9'h001;
  end
  assign below_min = (spd_q < 9'h010);
  // stands for the shared pin set up as a tach input by software
  assign speed_ok = (spd_q >= 9'(OK_LVL));
endmodule : fan_model

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic       mclk, clk_en = 1'b1, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic [6:0] remote_temp = 7'h00;
  logic [1:0] tach_mode_eff;
  logic       below, spd_ok, force1, pwm_in, pwm_out, pwm_oe, pin, pol = 1'b0;
  int         n_mismatch = 0, checks = 0, hi, lo, c;
  assign pin = pwm_oe ? pwm_out : 1'b1;
  fan_ctrl fan_ctrl_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .remote_temp(remote_temp), .tach_below_min(below), .tach_speed_ok(spd_ok),
    .tach_mode_eff(tach_mode_eff), .tach_force_ones(force1), .pwm_in(pwm_in),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe));
  fan_model fan_model_i (.mclk(mclk), .pin(pin), .pol(pol), .below_min(below),
    .speed_ok(spd_ok));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task summarize;
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask : rd
  task rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk("rdata", e, v);
  endtask : rc
  // the pin level is bounded so a stuck output ends the run
  task lvl(input logic l, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (n > 30000) begin
        n_mismatch++;
        summarize();
      end
    end while (pwm_in !== l);
  endtask : lvl
  // a partial and then one whole period first: a new duty or divider applies at once, mid-period
  task pm;
    repeat (2) begin
      lvl(1'b0, c);
      lvl(1'b1, c);
    end
    lvl(1'b0, hi);
    lvl(1'b1, lo);
  endtask : pm
  initial begin
    cyc(20);
    chk("oe", 8'h01, {7'h0, pwm_oe});
    @(posedge mclk) reset_n <= 1'b1;
    rc(8'h4A, 8'h20);
    rc(8'h4B, 8'h3F);
    rc(8'h4D, 8'h17);
    rc(8'h4C, 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(8'h4A, {4'h2, k[2], 1'b0, k[1:0]});
      cyc(8);
      chk("mode", {6'h0, k[1:0] & {2{k[2]}}}, {6'h0, tach_mode_eff});
      chk("ones", {7'h0, k[2] && k[1:0] != 2'h0}, {7'h0, force1});
    end
    wr(8'h4A, 8'hEB);
    rc(8'h4A, 8'h2B);
    wr(8'h4B, 8'h38);
    wr(8'h4A, 8'h20);
    wr(8'h4C, 8'h3F);
    rc(8'h4C, 8'h3F);
    cyc(3000);
    chk("oe", 8'h00, {7'h0, pwm_oe});
    wr(8'h4A, 8'h30);
    pol <= 1'b1;
    cyc(8);
    chk("oe", 8'h01, {7'h0, pwm_oe});
    wr(8'h4A, 8'h20);
    pol <= 1'b0;
    wr(8'h4D, 8'h00);
    wr(8'h4C, 8'h20);
    pm();
    chk("period", 8'h6E, 8'(hi + lo));
    wr(8'h4D, 8'h02);
    pm();
    chk("period", 8'hDC, 8'(hi + lo));
    wr(8'h4C, 8'h00);
    wr(8'h4D, 8'h01);
    wr(8'h4B, 8'hC9);
    rc(8'h4B, 8'h09);
    cyc(300);
    wr(8'h4C, 8'h10);
    rc(8'h4C, 8'h00);
    pm();
    chk("spin high", 8'h37, 8'(hi));
    wr(8'h4C, 8'h00);
    wr(8'h4B, 8'h01);
    cyc(300);
    wr(8'h4C, 8'h10);
    rc(8'h4C, 8'h10);
    wr(8'h4C, 8'h00);
    wr(8'h4B, 8'h21);
    cyc(800);
    wr(8'h4C, 8'h10);
    rc(8'h4C, 8'h00);
    cyc(115);
    for (int i = 0; i < 20; i++) begin
      cyc(1);
      chk("oe", 8'h00, {7'h0, pwm_oe});
    end
    c = 0;
    do begin
      rd(8'h4C);
      c++;
    end while (v !== 8'h10 && c < 200);
    chk("rdata", 8'h10, v);
    wr(8'h4C, 8'h00);
    wr(8'h4B, 8'h00);
    wr(8'h50, 8'h20);
    wr(8'h51, 8'h15);
    wr(8'h4A, 8'h00);
    remote_temp <= 7'h30;
    cyc(8);
    rc(8'h4C, 8'h15);
    wr(8'h4C, 8'h3F);
    rc(8'h4C, 8'h15);
    wr(8'h51, 8'h01);
    rc(8'h51, 8'h15);
    remote_temp <= 7'h10;
    cyc(8);
    rc(8'h4C, 8'h00);
    summarize();
  end
endmodule : tb_top
